// file: design/reset_config_latches.sv
// reset configuration latch block with AXI4-Lite register access
// assumes reset is held for at least six clock edges
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/100ps
// Function
// - keep a four-byte nonvolatile array that configures the device at reset
// - port field codes: analog hiz, digital hiz, pull-up, pull-down
// - a port's drive mode applies equally to all of its pins
// - external reset bit: 0 shared pin is GPIO, 1 external reset
// - debug enable bit: 0 blocks debug access, 1 allows it
// - factory programming leaves four-wire JTAG selected
// - ecc bit 1 uses the ecc area for correction, 0 frees it
// - four-bit field sets the digital clock phase delay
// - field placement across latch bytes zero to three
// - analog mode disables pulls and input buffer
module reset_config_latches
  import rcl_pkg::*;
#(
  parameter int PINS_PER_PORT = 8,
  parameter bit EXT_RESET_DEFAULT = 1'b0
)(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic factoryProgram,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [NUM_PORTS-1:0][PINS_PER_PORT-1:0] portInBufEn,
  output logic [NUM_PORTS-1:0][PINS_PER_PORT-1:0] portPullUp,
  output logic [NUM_PORTS-1:0][PINS_PER_PORT-1:0] portPullDown,
  output logic extResetPinSelect,
  output logic debugAccessEnable,
  output logic [1:0] debugPortSelect,
  output logic jtag5Enable,
  output logic jtag4Enable,
  output logic swdEnable,
  output logic eccAreaEnable,
  output logic [3:0] digitalClockPhaseDelay,
  output logic configLoaded
);

  if (PINS_PER_PORT < 1 || PINS_PER_PORT > 8)
  begin : gBadPins
    $error("PINS_PER_PORT must lie in 1 to 8");
  end

  localparam logic [7:0] DEF_PIN_DEBUG =
    DEF_BYTE2 | (EXT_RESET_DEFAULT ? 8'h80 : 8'h00);
  localparam logic [31:0] FACTORY_WORD =
    {DEF_BYTE3, DEF_PIN_DEBUG, DEF_BYTE1, DEF_BYTE0};

  function automatic logic [1:0] fieldOf(
    input logic [31:0] w,
    input int k
  );
    fieldOf = w[PORT_BYTE[k]*8 + PORT_LSB[k] +: 2];
  endfunction

  function automatic logic [2:0] regIdx(
    input logic [ADDR_W-1:0] a
  );
    regIdx = a[ADDR_W-1:2];
  endfunction

  latch_mem_if memBus ();

  config_latch_mem #(
    .DEFAULTS(FACTORY_WORD)
  ) uMem (
    .clock(clock),
    .sys_rst(sys_rst),
    .port(memBus.mem)
  );

  // reset-time loader state
  logic [2:0] loadCnt_q;
  logic [2:0] loadCnt_d;
  logic [7:0] applied_q [NUM_BYTES];
  logic configLoaded_q;
  logic [31:0] appliedWord;

  // write channel state
  logic awHeld_q;
  logic [ADDR_W-1:0] awAddr_q;
  logic wHeld_q;
  logic [7:0] wByte_q;
  logic wLane0_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic [15:0] wearCount_q;

  // read channel state
  rd_state_t rdState_q;
  rd_state_t rdState_d;
  logic [2:0] rdIdx_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // loader decode
  wire logic loadRun = (loadCnt_q != LOAD_DONE);
  wire logic capValid = sys_rst && (loadCnt_q != 3'h0) &&
    (loadCnt_q <= 3'(NUM_BYTES));
  wire logic [BIDX_W-1:0] capIdx = BIDX_W'(loadCnt_q - 3'h1);
  assign loadCnt_d = loadRun ? 3'(loadCnt_q + 3'h1) : loadCnt_q;

  // write decode
  wire logic awTake = s_axi_awvalid && s_axi_awready;
  wire logic wTake = s_axi_wvalid && s_axi_wready;
  wire logic doWrite = awHeld_q && wHeld_q;
  wire logic [2:0] wrRegIdx = regIdx(awAddr_q);
  wire logic wrIsLatch = (wrRegIdx < 3'(NUM_BYTES));
  wire logic wrIsStatus = (wrRegIdx == IDX_STATUS);
  wire logic memWrEn = doWrite && wrIsLatch && wLane0_q;
  wire logic [1:0] wrResp;
  assign wrResp = wrIsLatch ? RESP_OKAY
    : wrIsStatus ? RESP_SLVERR
    : RESP_DECERR;

  // read decode
  wire logic arTake = s_axi_arvalid && s_axi_arready;
  wire logic [2:0] arRegIdx = regIdx(s_axi_araddr);
  wire logic rdIsLatch = (rdIdx_q < 3'(NUM_BYTES));
  wire logic rdIsStatus = (rdIdx_q == IDX_STATUS);
  wire logic [31:0] statusWord;
  assign statusWord = {15'h0000, configLoaded_q, wearCount_q};
  wire logic [31:0] rdMux;
  wire logic [1:0] rdRespMux;
  assign rdMux = rdIsLatch ? {24'h000000, memBus.rdData}
    : rdIsStatus ? statusWord
    : 32'h00000000;
  assign rdRespMux = (rdIsLatch || rdIsStatus) ? RESP_OKAY : RESP_DECERR;

  // memory port: the loader owns the read port during reset
  assign memBus.rdIdx = sys_rst ? loadCnt_q[BIDX_W-1:0]
    : arRegIdx[BIDX_W-1:0];
  assign memBus.wrEn = memWrEn && !sys_rst;
  assign memBus.wrIdx = wrRegIdx[BIDX_W-1:0];
  assign memBus.wrData = wByte_q;
  assign memBus.factoryLoad = factoryProgram && !sys_rst;

  // loader counts only while reset is asserted
  always_ff @(posedge clock)
  begin
    loadCnt_q <= sys_rst ? loadCnt_d : 3'h0;
  end

  // applied values change only inside reset
  always_ff @(posedge clock)
  begin
    if (sys_rst && loadCnt_q == 3'h0)
    begin
      for (int i = 0; i < NUM_BYTES; i++)
        applied_q[i] <= FACTORY_WORD[i*8 +: 8];
    end
    else if (capValid)
      applied_q[capIdx] <= memBus.rdData;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      configLoaded_q <= (loadCnt_q == LOAD_DONE);
  end

  // write address and data are taken in either order
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      awHeld_q <= 1'b0;
    else if (awTake)
      awHeld_q <= 1'b1;
    else if (doWrite)
      awHeld_q <= 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      wHeld_q <= 1'b0;
    else if (wTake)
      wHeld_q <= 1'b1;
    else if (doWrite)
      wHeld_q <= 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      awAddr_q <= '0;
    else if (awTake)
      awAddr_q <= s_axi_awaddr;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      wByte_q <= 8'h00;
      wLane0_q <= 1'b0;
    end
    else if (wTake)
    begin
      wByte_q <= s_axi_wdata[7:0];
      wLane0_q <= s_axi_wstrb[0];
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      bvalid_q <= 1'b0;
    else if (doWrite)
      bvalid_q <= 1'b1;
    else if (s_axi_bready)
      bvalid_q <= 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      bresp_q <= RESP_OKAY;
    else if (doWrite)
      bresp_q <= wrResp;
  end

  // counts real latch wear events, identical rewrites are skipped
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      wearCount_q <= 16'h0000;
    else if (memBus.wore && wearCount_q != 16'hFFFF)
      wearCount_q <= 16'(wearCount_q + 16'h0001);
  end

  // read sequence: take address, fetch latch byte, answer
  always_comb
  begin
    rdState_d = rdState_q;
    case (rdState_q)
      RD_IDLE:
        if (s_axi_arvalid)
          rdState_d = RD_FETCH;
      RD_FETCH:
        rdState_d = RD_RESP;
      RD_RESP:
        if (s_axi_rready)
          rdState_d = RD_IDLE;
      default:
        rdState_d = RD_IDLE;
    endcase
  end

  always_ff @(posedge clock)
  begin
    rdState_q <= sys_rst ? RD_IDLE : rdState_d;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      rdIdx_q <= 3'h0;
    else if (arTake)
      rdIdx_q <= arRegIdx;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      rdata_q <= 32'h00000000;
      rresp_q <= RESP_OKAY;
    end
    else if (rdState_q == RD_FETCH)
    begin
      rdata_q <= rdMux;
      rresp_q <= rdRespMux;
    end
  end

  assign s_axi_awready = !awHeld_q && !bvalid_q;
  assign s_axi_wready = !wHeld_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = (rdState_q == RD_IDLE);
  assign s_axi_rvalid = (rdState_q == RD_RESP);
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // applied configuration
  assign appliedWord = {applied_q[3], applied_q[2], applied_q[1],
    applied_q[0]};
  wire logic [7:0] pinDebugByte = applied_q[IDX_PIN_DEBUG[1:0]];
  wire logic [7:0] clkEccByte = applied_q[IDX_CLK_ECC_DBG[1:0]];

  assign extResetPinSelect = pinDebugByte[EXT_RST_BIT];
  assign debugAccessEnable = pinDebugByte[DBG_EN_BIT];
  assign debugPortSelect = clkEccByte[DPS_LSB +: 2];
  assign eccAreaEnable = clkEccByte[ECC_BIT];
  assign digitalClockPhaseDelay = clkEccByte[PHASE_LSB +: 4];
  assign configLoaded = configLoaded_q;

  // debug ports open only with debug access enabled
  wire debug_port_t dpSel = debug_port_t'(debugPortSelect);
  assign jtag5Enable = debugAccessEnable && (dpSel == DP_JTAG5);
  assign jtag4Enable = debugAccessEnable && (dpSel == DP_JTAG4);
  assign swdEnable = debugAccessEnable && (dpSel == DP_SWD);

  for (genvar k = 0; k < NUM_PORTS; k++)
  begin : gPort
    port_drive_decoder #(
      .PINS(PINS_PER_PORT)
    ) uDec (
      .mode(drive_mode_t'(fieldOf(appliedWord, k))),
      .inBufEn(portInBufEn[k]),
      .pullUpEn(portPullUp[k]),
      .pullDownEn(portPullDown[k])
    );
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  analog_port_off_a: assert property (
    fieldOf(appliedWord, 0) == HIZ_ANALOG |->
      portInBufEn[0] == '0 && portPullUp[0] == '0 &&
      portPullDown[0] == '0)
    else $error("analog port has buffer or pull on");
  pull_up_mode_a: assert property (
    fieldOf(appliedWord, 8) == PULL_UP |->
      portPullUp[8] == '1 && portPullDown[8] == '0 &&
      portInBufEn[8] == '1)
    else $error("pull-up code not decoded");
  same_pin_mode_a: assert property (
    fieldOf(appliedWord, 4) == PULL_DOWN |->
      portPullDown[4] == '1 && portPullUp[4] == '0 &&
      portInBufEn[4] == '1)
    else $error("pins of one port differ");
  ext_pin_hold_a: assert property (
    memWrEn && wrRegIdx == IDX_PIN_DEBUG |=>
      $stable(extResetPinSelect) [*2])
    else $error("pin function changed outside reset");
  debug_block_a: assert property (
    !debugAccessEnable |-> !(jtag5Enable || jtag4Enable || swdEnable))
    else $error("debug port open while access blocked");
  debug_port_sel_a: assert property (
    debugAccessEnable |-> jtag4Enable == (debugPortSelect == 2'h1) &&
      swdEnable == (debugPortSelect == 2'h2))
    else $error("debug port select misdecoded");
  phase_hold_a: assert property (
    memWrEn && wrRegIdx == IDX_CLK_ECC_DBG |=>
      $stable(digitalClockPhaseDelay) ##1 $stable(eccAreaEnable))
    else $error("phase delay changed outside reset");
endmodule

// file: include/rcl_pkg.sv
// constants for the reset configuration latch block
// assumes a 32-bit AXI4-Lite register bus and a four-byte latch array
package rcl_pkg;
  localparam int NUM_BYTES = 4;
  localparam int NUM_PORTS = 9;
  localparam int ADDR_W = 5;
  localparam int BIDX_W = 2;
  // register indices, byte address is four times the index
  localparam logic [2:0] IDX_DRIVE_LOW = 3'h0;
  localparam logic [2:0] IDX_DRIVE_HIGH = 3'h1;
  localparam logic [2:0] IDX_PIN_DEBUG = 3'h2;
  localparam logic [2:0] IDX_CLK_ECC_DBG = 3'h3;
  localparam logic [2:0] IDX_STATUS = 3'h4;
  // field positions
  localparam int EXT_RST_BIT = 7;
  localparam int DBG_EN_BIT = 6;
  localparam int PHASE_LSB = 4;
  localparam int ECC_BIT = 2;
  localparam int DPS_LSB = 0;
  localparam int LOADED_BIT = 16;
  // byte and bit of each port field: ports 0-6, 12, 15
  localparam int PORT_BYTE [NUM_PORTS] = '{0, 0, 0, 0, 1, 1, 1, 1, 2};
  localparam int PORT_LSB [NUM_PORTS] = '{0, 2, 4, 6, 0, 2, 4, 6, 0};
  // factory values, byte 2 external reset bit comes from a parameter
  localparam logic [7:0] DEF_BYTE0 = 8'h00;
  localparam logic [7:0] DEF_BYTE1 = 8'h00;
  localparam logic [7:0] DEF_BYTE2 = 8'h40;
  localparam logic [7:0] DEF_BYTE3 = 8'h05;
  // reset edges needed to fetch all bytes
  localparam logic [2:0] LOAD_DONE = 3'h5;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  typedef enum logic [1:0] {
    HIZ_ANALOG = 2'h0,
    HIZ_DIGITAL = 2'h1,
    PULL_UP = 2'h2,
    PULL_DOWN = 2'h3
  } drive_mode_t;
  typedef enum logic [1:0] {
    DP_JTAG5 = 2'h0,
    DP_JTAG4 = 2'h1,
    DP_SWD = 2'h2,
    DP_OFF = 2'h3
  } debug_port_t;
  typedef enum logic [1:0] {
    RD_IDLE = 2'h0,
    RD_FETCH = 2'h1,
    RD_RESP = 2'h3
  } rd_state_t;
endpackage

// file: include/latch_mem_if.sv
// carrier between the register logic and the latch array
// assumes one clock shared by both ends
`timescale 1ns/100ps
interface latch_mem_if;
  import rcl_pkg::*;
  logic wrEn;
  logic [BIDX_W-1:0] wrIdx;
  logic [7:0] wrData;
  logic [BIDX_W-1:0] rdIdx;
  logic [7:0] rdData;
  logic factoryLoad;
  logic wore;
  modport mem (input wrEn, wrIdx, wrData, rdIdx, factoryLoad,
    output rdData, wore);
  modport user (output wrEn, wrIdx, wrData, rdIdx, factoryLoad,
    input rdData, wore);
endinterface

// file: design/config_latch_mem.sv
// nonvolatile latch array with one registered read port
// assumes the owner keeps write and factory load apart from reset
`timescale 1ns/100ps
module config_latch_mem
  import rcl_pkg::*;
#(
  parameter logic [31:0] DEFAULTS = 32'h0
)(
  input wire logic clock,
  input wire logic sys_rst,
  latch_mem_if.mem port
);
  // contents survive reset, so the cells have none
  logic [7:0] cells [NUM_BYTES];
  logic [7:0] rdData_q;
  logic wore_q;
  wire logic differs = port.wrEn && (cells[port.wrIdx] != port.wrData);

  always_ff @(posedge clock)
  begin
    if (port.factoryLoad)
    begin
      for (int i = 0; i < NUM_BYTES; i++)
        cells[i] <= DEFAULTS[i*8 +: 8];
    end
    else if (differs)
      cells[port.wrIdx] <= port.wrData;
  end

  always_ff @(posedge clock)
  begin
    rdData_q <= cells[port.rdIdx];
    wore_q <= sys_rst ? 1'b0 : (port.factoryLoad || differs);
  end

  assign port.rdData = rdData_q;
  assign port.wore = wore_q;

  store_byte_a: assert property (
    @(posedge clock) disable iff (sys_rst)
    port.wrEn && !port.factoryLoad |=> cells[$past(port.wrIdx)]
      == $past(port.wrData))
    else $error("latch byte not stored");
  factory_dps_a: assert property (
    @(posedge clock) disable iff (sys_rst)
    port.factoryLoad |=> cells[3][DPS_LSB +: 2] == DP_JTAG4)
    else $error("factory debug port not four-wire");
  factory_ecc_a: assert property (
    @(posedge clock) disable iff (sys_rst)
    port.factoryLoad |=> cells[3][ECC_BIT])
    else $error("factory ecc area not enabled");
endmodule

// file: design/port_drive_decoder.sv
// turns one port reset drive field into per-pin pad controls
// assumes the field is stable while reset configuration holds
`timescale 1ns/100ps
module port_drive_decoder
  import rcl_pkg::*;
#(
  parameter int PINS = 8
)(
  input drive_mode_t mode,
  output logic [PINS-1:0] inBufEn,
  output logic [PINS-1:0] pullUpEn,
  output logic [PINS-1:0] pullDownEn
);
  // analog mode keeps the input buffer off, no pull
  wire logic bufOn = (mode != HIZ_ANALOG);
  wire logic upOn = (mode == PULL_UP);
  wire logic downOn = (mode == PULL_DOWN);
  assign inBufEn = {PINS{bufOn}};
  assign pullUpEn = {PINS{upOn}};
  assign pullDownEn = {PINS{downOn}};
endmodule

// file: verif/latch_programmer.sv
// external programmer model that loads factory values into the latches
// assumes one clock shared with the block and an active high reset
`timescale 1ns/100ps
module latch_programmer (
  input wire logic clock,
  input wire logic sysRst,
  input wire logic programReq,
  output logic factoryProgram
);
  logic reqSeen;

  // one pulse per request raised while reset is low, never repeated, to spare latch wear
  always_ff @(posedge clock)
  begin
    reqSeen <= programReq;
    factoryProgram <= programReq && !reqSeen && !sysRst;
  end
endmodule

// file: verif/reset_config_latches_tb.sv
// self-checking bench for the reset configuration latch block
// assumes the programmer model and the register package are compiled first
`timescale 1ns/100ps
module reset_config_latches_tb;
  import rcl_pkg::*;
  logic clock, sysRst, fp, pReq;
  logic [4:0] awAddr, arAddr;
  logic awValid, awReady, wValid, wReady, bValid, bReady;
  logic arValid, arReady, rValid, rReady;
  logic [31:0] wData, rData;
  logic [3:0] wStrb;
  logic [1:0] bResp, rResp, dps;
  logic [8:0][7:0] inBuf, pUp, pDn;
  logic extSel, debug_access_enable, j5, j4, swd, ecc, loaded;
  logic [3:0] phase;
  logic [1:0] resp;
  logic [7:0] rd;
  logic [31:0] rdw;
  int nFail, checks;

  reset_config_latches reset_config_latches_i (.clock(clock),
    .sys_rst(sysRst), .factoryProgram(fp), .s_axi_awaddr(awAddr),
    .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
    .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
    .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
    .s_axi_rvalid(rValid), .s_axi_rready(rReady), .portInBufEn(inBuf),
    .portPullUp(pUp), .portPullDown(pDn), .extResetPinSelect(extSel),
    .debugAccessEnable(debug_access_enable), .debugPortSelect(dps), .jtag5Enable(j5),
    .jtag4Enable(j4), .swdEnable(swd), .eccAreaEnable(ecc),
    .digitalClockPhaseDelay(phase), .configLoaded(loaded));

  latch_programmer latch_programmer_i (.clock(clock), .sysRst(sysRst),
    .programReq(pReq), .factoryProgram(fp));

  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, nFail);
    if (nFail == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] e, g);
    checks++;
    if (g !== e)
    begin
      nFail++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic do_reset(input int n);
    @(posedge clock);
    sysRst <= 1'b1;
    repeat (n) @(posedge clock);
    sysRst <= 1'b0;
    repeat (2) @(posedge clock);
  endtask

  task automatic axi_write(input logic [4:0] a, input logic [7:0] d);
    bit aw, w, b;
    int n;
    aw = 0; w = 0; b = 0; n = 0;
    awAddr <= a; wData <= {24'h0, d};
    awValid <= 1'b1; wValid <= 1'b1; bReady <= 1'b1;
    while (!b && n < 50)
    begin
      @(negedge clock);
      aw = awValid && awReady;
      w = wValid && wReady;
      b = bValid && bReady;
      resp = bResp;
      @(posedge clock);
      if (aw) awValid <= 1'b0;
      if (w) wValid <= 1'b0;
      n++;
    end
    bReady <= 1'b0;
    chk("write done", 1, b);
    @(posedge clock);
  endtask

  task automatic axi_read(input logic [4:0] a);
    bit ar, r;
    int n;
    ar = 0; r = 0; n = 0;
    arAddr <= a; arValid <= 1'b1; rReady <= 1'b1;
    while (!r && n < 50)
    begin
      @(negedge clock);
      ar = arValid && arReady;
      r = rValid && rReady;
      resp = rResp;
      rdw = rData;
      @(posedge clock);
      if (ar) arValid <= 1'b0;
      n++;
    end
    rReady <= 1'b0;
    chk("read done", 1, r);
    if (a != 5'h10)
      chk("rdata high", 0, rdw[31:8]);
    rd = rdw[7:0];
    @(posedge clock);
  endtask

  task automatic chk_config(input logic [7:0] b0, b1, b2, b3);
    logic [7:0] bt;
    logic [1:0] f;
    for (int s = 0; s < 9; s++)
    begin
      bt = (s < 4) ? b0 : ((s < 8) ? b1 : b2);
      f = bt[2*(s%4) +: 2];
      chk("inBuf", {8{f != 2'h0}}, inBuf[s]);
      chk("pullUp", {8{f == 2'h2}}, pUp[s]);
      chk("pullDown", {8{f == 2'h3}}, pDn[s]);
    end
    chk("extSel", b2[7], extSel);
    chk("debug_access_enable", b2[6], debug_access_enable);
    chk("dps", b3[1:0], dps);
    chk("jtag5", b2[6] && b3[1:0] == 2'h0, j5);
    chk("jtag4", b2[6] && b3[1:0] == 2'h1, j4);
    chk("swd", b2[6] && b3[1:0] == 2'h2, swd);
    chk("ecc", b3[2], ecc);
    chk("phase", b3[7:4], phase);
    chk("loaded", 1, loaded);
  endtask

  task automatic test_defaults;
    logic [7:0] exp [4];
    exp = '{8'h00, 8'h00, 8'h40, 8'h05};
    chk_config(8'h00, 8'h00, 8'h40, 8'h05);
    for (int i = 0; i < 4; i++)
    begin
      axi_read(5'(4*i));
      chk("default byte", exp[i], rd);
      chk("rresp", RESP_OKAY, resp);
    end
  endtask

  task automatic test_hold;
    logic [7:0] v [4];
    v = '{8'hE4, 8'h1B, 8'h83, 8'hA6};
    for (int i = 0; i < 4; i++)
      axi_write(5'(4*i), v[i]);
    chk_config(8'h00, 8'h00, 8'h40, 8'h05);
    for (int i = 0; i < 4; i++)
    begin
      axi_read(5'(4*i));
      chk("stored byte", v[i], rd);
    end
    do_reset(8);
    chk_config(v[0], v[1], v[2], v[3]);
  endtask

  task automatic test_debug_ports;
    for (int d = 0; d < 4; d++)
    begin
      axi_write(5'h08, 8'h42);
      axi_write(5'h0C, {4'(d + 3), 2'h0, 2'(d)});
      do_reset(6);
      chk_config(8'hE4, 8'h1B, 8'h42, {4'(d + 3), 2'h0, 2'(d)});
    end
  endtask

  task automatic test_errors;
    axi_read(5'h14);
    chk("unmapped resp", RESP_DECERR, resp);
    chk("unmapped data", 0, rd);
    axi_write(5'h10, 8'h55);
    chk("status write resp", RESP_SLVERR, resp);
    axi_write(5'h14, 8'h55);
    chk("unmapped write resp", RESP_DECERR, resp);
    wStrb <= 4'hE;
    axi_write(5'h00, 8'h11);
    chk("no strobe resp", RESP_OKAY, resp);
    wStrb <= 4'hF;
    axi_write(5'h00, 8'hE4);
    axi_write(5'h04, 8'h1C);
    axi_read(5'h00);
    chk("no strobe byte", 8'hE4, rd);
    axi_read(5'h10);
    chk("status", 32'h00010001, rdw);
    do_reset(2);
    chk("short reset", 0, loaded);
  endtask

  initial
  begin
    sysRst = 1'b1; pReq = 1'b0; wStrb = 4'hF;
    awAddr = '0; arAddr = '0; wData = '0;
    awValid = 0; wValid = 0; bReady = 0; arValid = 0; rReady = 0;
    nFail = 0; checks = 0;
    repeat (16) @(posedge clock);
    sysRst <= 1'b0;
    repeat (2) @(posedge clock);
    pReq <= 1'b1;
    repeat (3) @(posedge clock);
    pReq <= 1'b0;
    do_reset(8);
    test_defaults();
    test_hold();
    test_debug_ports();
    test_errors();
    wrap_up();
  end

  initial
  begin
    repeat (20000) @(posedge clock);
    nFail++;
    wrap_up();
  end
endmodule
